// ### design/lbdha_top.sv
// Local bus DMA request handshake and slave cycle acknowledge.
`timescale 1ns/1ps
// Operation
// (R1) Processor DMA asserts end-of-sequence when finished.
// (R2) After end-of-sequence, stop requesting further transfers.
// (R3) Request DMA to fill or drain inbound FIFO.
// (R4) Request output changes on falling clock edge.
// (R5) Addressed slave drives both acknowledge lines together.
// (R6) Every slave cycle ends with both acknowledges asserted.
// (R7) Upper acknowledge driven high one edge, then floats.
// (R8) Lower acknowledge behaves exactly like upper one.
// (R9) DMA acknowledge input marks cycle, strobe timing.
// (R10) All local bus logic runs on its clock.
module lbdha_top
   import lbdha_pkg::*;
#(
   parameter int COUNT_W = XFER_COUNT_W
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Local bus cycle pins
   input wire logic addrStrobeN,
   input wire logic dmaCycleAckN,
   // Processor DMA handshake pins
   input wire logic dmaDoneN,
   output logic dmaTransferRequestN,
   // Upper acknowledge two-way pin
   input wire logic sizeAckHighNIn,
   output logic sizeAckHighNOut,
   output logic sizeAckHighNOe,
   // Lower acknowledge two-way pin
   input wire logic sizeAckLowNIn,
   output logic sizeAckLowNOut,
   output logic sizeAckLowNOe,
   // Bridge core side: DMA sequence control
   input wire logic seqArm,
   input wire logic fifoHasRoom,
   input wire logic fifoHasData,
   input wire logic preferWrite,
   // Bridge core side: slave cycle control
   input wire logic slaveSelect,
   input wire logic termReady,
   // Bridge core side: status
   output logic dmaDirWrite,
   output logic seqDone,
   output logic cycleDone,
   output logic cycleIsDma,
   output logic foreignAckSeen,
   output logic [COUNT_W-1:0] xferCount
);

   if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count_w
      $error("COUNT_W must lie between 1 and 32");
   end

   lbdha_ack_if ackHighIf ();
   lbdha_ack_if ackLowIf ();

   logic doneSeen_ff;
   logic dirWrite_ff;
   logic reqN_ff;
   logic acked_ff;
   logic cycleDone_ff;
   logic cycleIsDma_ff;
   logic foreignAck_ff;
   logic [COUNT_W-1:0] xferCount_ff;

   logic strobeActive;
   logic ackGo;
   logic wantWrite;
   logic wantRead;
   logic nxt_reqN;
   logic nxt_dirWrite;

   // ---------------------------------------------------------------
   // DMA request side. The end-of-sequence input has its setup to the
   // falling edge, so it is sampled there, and the request flop also
   // sits on the falling edge. All pins are synchronous to ref_clk, so
   // no synchroniser is needed.
   // ---------------------------------------------------------------

   // R10

   assign wantWrite = fifoHasRoom; // R3
   assign wantRead = fifoHasData; // R3

   // The done flag is set by the processor and cleared by a new arm.
   // Setting wins, so an end-of-sequence on the arming edge is kept.
   always_ff @(negedge ref_clk) begin
      if (!rst_n) begin
         doneSeen_ff <= RST_DONE_SEEN;
      end else if (dmaDoneN == PIN_ASSERTED) begin
         doneSeen_ff <= 1'h1; // R2
      end else if (seqArm) begin
         doneSeen_ff <= 1'h0;
      end
   end

   // A write is chosen when only room exists or when both directions are
   // possible and the core prefers writes; the direction is held while a
   // request stands so the processor never sees it change mid-request.
   always_comb begin
      nxt_dirWrite = dirWrite_ff;
      if (reqN_ff == PIN_INACTIVE) begin
         if (wantWrite && (!wantRead || preferWrite)) begin
            nxt_dirWrite = 1'h1;
         end else if (wantRead) begin
            nxt_dirWrite = 1'h0;
         end
      end
   end

   // The request drops on the same falling edge that first sees the
   // end-of-sequence, not one cycle later.
   always_comb begin
      nxt_reqN = PIN_INACTIVE;
      if (dmaDoneN == PIN_INACTIVE && !doneSeen_ff) begin // R2
         if (nxt_dirWrite ? wantWrite : wantRead) begin
            nxt_reqN = PIN_ASSERTED; // R3
         end
      end
   end

   always_ff @(negedge ref_clk) begin
      if (!rst_n) begin
         reqN_ff <= RST_REQ_N;
         dirWrite_ff <= RST_DIR_WRITE;
      end else begin
         reqN_ff <= nxt_reqN; // R4
         dirWrite_ff <= nxt_dirWrite;
      end
   end

   // ---------------------------------------------------------------
   // Slave cycle termination.
   // ---------------------------------------------------------------

   assign strobeActive = (addrStrobeN == PIN_ASSERTED);

   // One acknowledge per strobe; a new one only after both lines have
   // floated again, so a back-to-back strobe cannot clip the negation.
   assign ackGo = strobeActive && slaveSelect && termReady && !acked_ff &&
                  !ackHighIf.busy && !ackLowIf.busy;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         acked_ff <= RST_FLAG;
      end else if (ackGo) begin
         acked_ff <= 1'h1;
      end else if (!strobeActive) begin
         acked_ff <= 1'h0;
      end
   end

   // Both lines get the same go and release, so they always move together
   // and the cycle always reports a full-width port.
   assign ackHighIf.go = ackGo; // R6
   assign ackLowIf.go = ackGo; // R5
   assign ackHighIf.strobeReleased = !strobeActive; // R7
   assign ackLowIf.strobeReleased = !strobeActive; // R8

   lbdha_ack_drv i_lbdha_ack_drv_hi (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .ackIf   (ackHighIf)
   );

   lbdha_ack_drv i_lbdha_ack_drv_lo (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .ackIf   (ackLowIf)
   );

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cycleDone_ff <= RST_FLAG;
         cycleIsDma_ff <= RST_FLAG;
      end else begin
         cycleDone_ff <= ackGo;
         if (ackGo) begin
            cycleIsDma_ff <= (dmaCycleAckN == PIN_ASSERTED); // R9
         end
      end
   end

   // Counts DMA cycles acknowledged since the last arm. It wraps silently;
   // the core is expected to size COUNT_W for its longest sequence.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         xferCount_ff <= '0;
      end else if (seqArm) begin
         xferCount_ff <= '0;
      end else if (ackGo && dmaCycleAckN == PIN_ASSERTED) begin
         xferCount_ff <= xferCount_ff + COUNT_W'(1);
      end
   end

   // Another slave terminating a cycle while our lines float.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         foreignAck_ff <= RST_FLAG;
      end else begin
         foreignAck_ff <= (sizeAckHighNIn == PIN_ASSERTED) &&
                          (sizeAckLowNIn == PIN_ASSERTED) &&
                          (ackHighIf.pinEnable == OE_FLOAT);
      end
   end

   // ---------------------------------------------------------------
   // Outputs, each straight from a flip-flop.
   // ---------------------------------------------------------------

   assign dmaTransferRequestN = reqN_ff;
   assign dmaDirWrite = dirWrite_ff;
   assign seqDone = doneSeen_ff;
   assign sizeAckHighNOut = ackHighIf.pinLevel; // R6
   assign sizeAckHighNOe = ackHighIf.pinEnable;
   assign sizeAckLowNOut = ackLowIf.pinLevel; // R8
   assign sizeAckLowNOe = ackLowIf.pinEnable;
   assign cycleDone = cycleDone_ff;
   assign cycleIsDma = cycleIsDma_ff;
   assign foreignAckSeen = foreignAck_ff;
   assign xferCount = xferCount_ff;

endmodule : lbdha_top

// ### include/lbdha_pkg.sv
// Package of constants and types for the local bus DMA handshake block.
package lbdha_pkg;

   // Active-low pin levels.
   localparam logic PIN_ASSERTED = 1'h0;
   localparam logic PIN_INACTIVE = 1'h1;

   // Output enable levels of the two-way acknowledge pins.
   localparam logic OE_DRIVE = 1'h1;
   localparam logic OE_FLOAT = 1'h0;

   // Values after reset.
   localparam logic RST_REQ_N = 1'h1;
   localparam logic RST_DONE_SEEN = 1'h0;
   localparam logic RST_DIR_WRITE = 1'h0;
   localparam logic RST_FLAG = 1'h0;

   // Default width of the per-sequence transfer counter.
   localparam int XFER_COUNT_W = 16;

   // Count of clock edges that an acknowledge line is driven high
   // after the address strobe is released.
   localparam int NEGATE_CYCLES = 1;

   // Acknowledge line driver states, Gray coded from float through drive to negate.
   typedef enum logic [1:0] {
      ACK_FLOAT  = 2'h0,
      ACK_DRIVE  = 2'h1,
      ACK_NEGATE = 2'h3
   } lbdha_ack_state_t;

endpackage : lbdha_pkg

// ### include/lbdha_ack_if.sv
// Interface between the top module and one acknowledge line driver.
`timescale 1ns/1ps
interface lbdha_ack_if;
   logic go;
   logic strobeReleased;
   logic pinLevel;
   logic pinEnable;
   logic busy;

   modport ctrl (output go, output strobeReleased,
                 input pinLevel, input pinEnable, input busy);
   modport drv (input go, input strobeReleased,
                output pinLevel, output pinEnable, output busy);
endinterface : lbdha_ack_if

// ### design/lbdha_ack_drv.sv
// Driver of one data-and-size acknowledge line with rescinding tristate.
`timescale 1ns/1ps
module lbdha_ack_drv
   import lbdha_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Control from the top module
   lbdha_ack_if.drv ackIf
);

   lbdha_ack_state_t state_ff;
   lbdha_ack_state_t nxt_state;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ACK_FLOAT: begin
            if (ackIf.go) begin
               nxt_state = ACK_DRIVE;
            end
         end
         ACK_DRIVE: begin
            if (ackIf.strobeReleased) begin
               nxt_state = ACK_NEGATE; // R7
            end
         end
         ACK_NEGATE: begin
            nxt_state = ACK_FLOAT; // R7
         end
         default: begin
            nxt_state = ACK_FLOAT;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff <= ACK_FLOAT;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Pin level and enable are registered from the next state so that the
   // line changes on the same edge as the state, glitch free.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ackIf.pinLevel <= PIN_INACTIVE;
         ackIf.pinEnable <= OE_FLOAT;
      end else begin
         ackIf.pinLevel <= (nxt_state == ACK_DRIVE) ? PIN_ASSERTED
                                                    : PIN_INACTIVE; // R7
         ackIf.pinEnable <= (nxt_state == ACK_FLOAT) ? OE_FLOAT
                                                     : OE_DRIVE; // R7
      end
   end

   assign ackIf.busy = (state_ff != ACK_FLOAT);

endmodule : lbdha_ack_drv

// ### testbench/lbdha_top_sva.sv
// Concurrent checks of the DMA request and acknowledge pins.
`timescale 1ns/1ps
module lbdha_top_sva
   import lbdha_pkg::*;
#(
   parameter int COUNT_W = XFER_COUNT_W
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Local bus and DMA pins
   input wire logic addrStrobeN,
   input wire logic dmaCycleAckN,
   input wire logic dmaDoneN,
   input wire logic dmaTransferRequestN,
   // Acknowledge pins
   input wire logic sizeAckHighNIn,
   input wire logic sizeAckHighNOut,
   input wire logic sizeAckHighNOe,
   input wire logic sizeAckLowNIn,
   input wire logic sizeAckLowNOut,
   input wire logic sizeAckLowNOe,
   // Core side
   input wire logic seqArm,
   input wire logic fifoHasRoom,
   input wire logic fifoHasData,
   input wire logic preferWrite,
   input wire logic slaveSelect,
   input wire logic termReady,
   input wire logic dmaDirWrite,
   input wire logic seqDone,
   input wire logic cycleDone,
   input wire logic cycleIsDma,
   input wire logic foreignAckSeen,
   input wire logic [COUNT_W-1:0] xferCount
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_stop; @(negedge ref_clk) !dmaDoneN |=> dmaTransferRequestN;
   endproperty
   a_stop: assert property (p_stop) else $error("req after done");
   property p_hold; @(negedge ref_clk) seqDone |-> dmaTransferRequestN;
   endproperty
   a_hold: assert property (p_hold) else $error("req while done");
   property p_wr; @(negedge ref_clk) dmaTransferRequestN && fifoHasRoom &&
      !fifoHasData && dmaDoneN && !seqDone |=> !dmaTransferRequestN &&
      dmaDirWrite; endproperty
   a_wr: assert property (p_wr) else $error("no write request");
   property p_rd; @(negedge ref_clk) dmaTransferRequestN && fifoHasData &&
      !fifoHasRoom && dmaDoneN && !seqDone |=> !dmaTransferRequestN &&
      !dmaDirWrite; endproperty
   a_rd: assert property (p_rd) else $error("no read request");
   // Sampled clock is low at a rising edge, so changes land on falls.
   property p_edge; @(ref_clk) $changed(dmaTransferRequestN) |-> !ref_clk;
   endproperty
   a_edge: assert property (p_edge) else $error("req on rise");
   property p_go; $fell(addrStrobeN) && slaveSelect && termReady &&
      !sizeAckHighNOe |=> cycleDone && !sizeAckHighNOut && !sizeAckLowNOut;
   endproperty
   a_go: assert property (p_go) else $error("cycle not acked");
   property p_keep; !addrStrobeN && !sizeAckHighNOut |=> !sizeAckHighNOut;
   endproperty
   a_keep: assert property (p_keep) else $error("ack dropped");
   property p_neg; $rose(addrStrobeN) && !sizeAckHighNOut |=>
      sizeAckHighNOut && sizeAckHighNOe ##1 !sizeAckHighNOe; endproperty
   a_neg: assert property (p_neg) else $error("bad ack release");
   property p_pair; sizeAckHighNOut == sizeAckLowNOut &&
      sizeAckHighNOe == sizeAckLowNOe; endproperty
   a_pair: assert property (p_pair) else $error("acks differ");
   c_dma: cover property (cycleDone && cycleIsDma);
   c_done: cover property (@(negedge ref_clk) seqDone);
   c_rd: cover property (!dmaTransferRequestN && !dmaDirWrite);
   c_foreign: cover property (foreignAckSeen);
endmodule : lbdha_top_sva
bind lbdha_top lbdha_top_sva #(.COUNT_W(COUNT_W)) i_lbdha_top_sva (.*);

// ### testbench/lbdha_cpu_model.sv
// Behavioural processor bus and DMA controller facing the bridge.
`timescale 1ns/1ps
module lbdha_cpu_model (
   // Clock and sensed pins
   input wire logic ref_clk,
   input wire logic ackHighN,
   input wire logic ackLowN,
   // Driven pins
   output logic strobeN = 1'h1,
   output logic dmaAckN = 1'h1,
   output logic doneN = 1'h1
);
   // Idle gap first, so the lines have floated before a new strobe.
   task automatic cycle(input logic isDma, output logic acked);
      int n;
      repeat (3) @(posedge ref_clk);
      #2 strobeN = 1'h0;
      dmaAckN = ~isDma;
      acked = 1'h0;
      for (n = 0; n < 6 && !acked; n++) begin
         @(posedge ref_clk) #2;
         acked = !ackHighN && !ackLowN;
      end
      @(posedge ref_clk) #2;
      strobeN = 1'h1;
      dmaAckN = 1'h1;
   endtask : cycle
   task automatic finish();
      @(posedge ref_clk) #2;
      doneN = 1'h0;
      @(posedge ref_clk) #2;
      doneN = 1'h1;
   endtask : finish
endmodule : lbdha_cpu_model

// ### testbench/test_lbdha_top.sv
// Self-checking bench of the DMA handshake and acknowledge block.
`timescale 1ns/1ps
module test_lbdha_top;
   import lbdha_pkg::*;
   logic ref_clk = 1'h0;
   logic rst_n = 1'h0;
   logic seqArm = 1'h0;
   logic room = 1'h0;
   logic data = 1'h0;
   logic sel = 1'h0;
   logic ready = 1'h0;
   logic prefer = 1'h0;
   logic other = 1'h0;
   logic foreign;
   logic strobeN, dmaAckN, doneN, reqN, hiOut, hiOe, loOut, loOe;
   logic hiPin, loPin, dirWrite, seqDone, cycleDone, isDma, acked;
   logic [3:0] count;
   int bad_count = 0;
   int check_count = 0;
   int pulseCount = 0;
   // Both acknowledge lines are pulled up while nobody drives them; other
   // stands for a second slave that pulls both low together.
   assign hiPin = hiOe ? hiOut : ~other;
   assign loPin = loOe ? loOut : ~other;
   always #10 ref_clk = ~ref_clk;
   lbdha_top #(.COUNT_W(4)) i_lbdha_top (.ref_clk(ref_clk), .rst_n(rst_n),
      .addrStrobeN(strobeN), .dmaCycleAckN(dmaAckN), .dmaDoneN(doneN),
      .dmaTransferRequestN(reqN), .sizeAckHighNIn(hiPin),
      .sizeAckHighNOut(hiOut), .sizeAckHighNOe(hiOe),
      .sizeAckLowNIn(loPin), .sizeAckLowNOut(loOut), .sizeAckLowNOe(loOe),
      .seqArm(seqArm), .fifoHasRoom(room), .fifoHasData(data),
      .preferWrite(prefer), .slaveSelect(sel), .termReady(ready),
      .dmaDirWrite(dirWrite), .seqDone(seqDone), .cycleDone(cycleDone),
      .cycleIsDma(isDma), .foreignAckSeen(foreign), .xferCount(count));
   // Pulses are counted on the falling edge, half a cycle clear of the
   // rising edge that launches them.
   always @(negedge ref_clk) begin
      if (cycleDone === 1'h1) begin
         pulseCount++;
      end
   end
   lbdha_cpu_model i_lbdha_cpu_model (.ref_clk(ref_clk), .ackHighN(hiPin),
      .ackLowN(loPin), .strobeN(strobeN), .dmaAckN(dmaAckN), .doneN(doneN));
   task automatic check(input string name, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %b, seen %b", name, exp, got);
      end
   endtask : check
   task automatic stop_test();
      if (bad_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic step();
      @(posedge ref_clk) #2;
   endtask : step
   task automatic t_write();
      step();
      room = 1'h1;
      #5 check("req", 1'h1, reqN);
      #6 check("req", 1'h0, reqN);
      check("dir", 1'h1, dirWrite);
   endtask : t_write
   // The request must stay off after done until a new arm.
   task automatic t_done();
      i_lbdha_cpu_model.finish();
      repeat (3) step();
      check("req", 1'h1, reqN);
      check("seqDone", 1'h1, seqDone);
      seqArm = 1'h1;
      step();
      seqArm = 1'h0;
      step();
      check("req", 1'h0, reqN);
      check("seqDone", 1'h0, seqDone);
      room = 1'h0;
      step();
      data = 1'h1;
      step();
      check("req", 1'h0, reqN);
      check("dir", 1'h0, dirWrite);
      data = 1'h0;
   endtask : t_done
   // With room and data both present the preference picks the direction.
   task automatic t_prefer();
      step();
      room = 1'h1;
      data = 1'h1;
      prefer = 1'h1;
      step();
      check("req", 1'h0, reqN);
      check("dir", 1'h1, dirWrite);
      room = 1'h0;
      data = 1'h0;
      prefer = 1'h0;
      step();
      room = 1'h1;
      data = 1'h1;
      step();
      check("req", 1'h0, reqN);
      check("dir", 1'h0, dirWrite);
      room = 1'h0;
      data = 1'h0;
   endtask : t_prefer
   task automatic t_ack();
      sel = 1'h1;
      ready = 1'h1;
      i_lbdha_cpu_model.cycle(1'h0, acked);
      check("acked", 1'h1, acked);
      check("isDma", 1'h0, isDma);
      i_lbdha_cpu_model.cycle(1'h1, acked);
      check("acked", 1'h1, acked);
      check("isDma", 1'h1, isDma);
      check("count", 1'h1, count === 4'h1);
      step();
      check("high", 1'h1, hiPin & hiOe);
      check("low", 1'h1, loPin & loOe);
      step();
      check("float", 1'h0, hiOe | loOe);
      sel = 1'h0;
      i_lbdha_cpu_model.cycle(1'h1, acked);
      check("acked", 1'h0, acked);
      check("pulses", 1'h1, pulseCount == 2);
   endtask : t_ack
   // A second slave ends a cycle while both of our lines float.
   task automatic t_foreign();
      other = 1'h1;
      step();
      check("foreign", 1'h1, foreign);
      check("oe", 1'h0, hiOe | loOe);
      other = 1'h0;
      step();
      check("foreign", 1'h0, foreign);
   endtask : t_foreign
   // A reset in mid-run drops a standing request and clears the counter.
   task automatic t_reset();
      room = 1'h1;
      repeat (2) step();
      check("req", 1'h0, reqN);
      rst_n = 1'h0;
      repeat (2) step();
      check("req", 1'h1, reqN);
      check("count", 1'h1, count === 4'h0);
      check("seqDone", 1'h0, seqDone);
      rst_n = 1'h1;
      repeat (2) step();
      check("req", 1'h0, reqN);
      room = 1'h0;
   endtask : t_reset
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      #2 rst_n = 1'h1;
      check("req", 1'h1, reqN);
      check("oe", 1'h0, hiOe | loOe);
      t_write();
      t_done();
      t_prefer();
      t_ack();
      t_foreign();
      t_reset();
      stop_test();
   end
endmodule : test_lbdha_top
